// ==== logic/mso_stop_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - A Halt request stops the ongoing movement, and withdrawing it resumes that movement.
// - Halt comes from the fieldbus or from a digital input that has been given the halt function.
// - A Halt withdrawn during braking still brakes to standstill before accelerating back.
// - The halt reaction selects deceleration ramp (1) or torque ramp (3), default 3, effective at once.
// - Deceleration-ramp braking is used only in modes with a velocity profile, else the torque ramp.
// - Halt on the deceleration ramp uses the profile deceleration.
// - The halt current limit is held in 0.01 A peak steps with a motor-dependent bound, effective at once.
// - A Quick Stop starts on a fieldbus command or on an error of class 1 or 2.
// - Quick stop reaction -2/-1/6/7 chooses torque or deceleration ramp and fault or stay, default 7.
// - The state shows 6 during Quick Stop braking and moves to 7 or to 9 Fault at standstill as selected.
// - The quick stop ramp is 200 to 3000000 RPM/s, default 6000, for software and error stops.
// - A new quick stop ramp takes effect only at the start of the next movement.
// - The quick stop current limit is held in 0.01 A peak steps with a motor-dependent bound, effective at once.
// - Bit i of the direct output setting drives digital output i.
// - Writes change only outputs that are free for use and are ignored for the others.
module mso_stop_ctrl #(
  parameter int unsigned N_OUT = 16,
  parameter logic [15:0] CURR_MAX = 16'h03e8,
  parameter logic [15:0] CURR_RST = 16'h01f4
) (
  input wire logic mclk,
  input wire logic resetn,
  // Fieldbus parameter access
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [15:0] par_addr,
  input wire logic [31:0] par_wdata,
  output logic [31:0] par_rdata_q,
  output logic par_ack_q,
  output logic par_nak_q,
  // Stop requests
  input wire logic halt_in,
  input wire logic halt_func_en,
  input wire logic fb_halt,
  input wire logic fb_qstop,
  input wire logic err_class1,
  input wire logic err_class2,
  input wire logic qstop_release,
  input wire logic fault_reset,
  // Motion status
  input wire logic profile_mode,
  input wire logic standstill,
  input wire logic move_start,
  input wire logic [31:0] profile_deceleration,
  // Braking commands to the ramp generator
  output logic brake_active_q,
  output logic brake_torque_q,
  output logic [31:0] brake_decel_q,
  output logic [15:0] brake_current_q,
  output logic resume_q,
  output logic [3:0] op_state_q,
  // Digital outputs
  input wire logic [N_OUT-1:0] out_free_use,
  input wire logic [N_OUT-1:0] out_func_level,
  output logic [N_OUT-1:0] dout_q
);

  if (N_OUT < 1 || N_OUT > 16) begin : g_nout_chk
    $error("mso_stop_ctrl: N_OUT must be 1 to 16");
  end
  if (CURR_RST > CURR_MAX) begin : g_curr_chk
    $error("mso_stop_ctrl: CURR_RST above CURR_MAX");
  end

  logic [31:0] qs_decel_q;
  logic [31:0] qs_decel_act_q;
  logic [15:0] halt_react_q;
  logic [15:0] qs_react_q;
  logic [15:0] dout_set_q;
  logic [15:0] qs_curr_q;
  logic [15:0] halt_curr_q;
  mso_pkg::mso_state_e state_q;
  mso_pkg::mso_state_e state_d;
  logic halt_req;
  logic qs_req;
  logic halt_tq;
  logic qs_tq;
  logic qs_to_fault;
  logic wr_ok;
  logic [15:0] free16;

  function automatic logic qs_code_ok(input logic [15:0] c);
    qs_code_ok = (c == mso_pkg::QSR_TQ_FAULT) || (c == mso_pkg::QSR_DEC_FAULT) ||
                 (c == mso_pkg::QSR_DEC_STAY) || (c == mso_pkg::QSR_TQ_STAY);
  endfunction

  // Request decoding
  assign halt_req = fb_halt | (halt_in & halt_func_en);
  assign qs_req = fb_qstop | err_class1 | err_class2;
  assign halt_tq = (halt_react_q == mso_pkg::HALT_TORQUE) | ~profile_mode;
  assign qs_tq = (qs_react_q == mso_pkg::QSR_TQ_FAULT) | (qs_react_q == mso_pkg::QSR_TQ_STAY) | ~profile_mode;
  assign qs_to_fault = qs_react_q[15];
  assign free16 = 16'(out_free_use);

  // Write validation
  always_comb begin
    case (par_addr)
      mso_pkg::OFS_QS_DECEL: wr_ok = (par_wdata >= mso_pkg::QS_DECEL_MIN) && (par_wdata <= mso_pkg::QS_DECEL_MAX);
      mso_pkg::OFS_HALT_REACT: wr_ok = (par_wdata[15:0] == mso_pkg::HALT_DECEL) || (par_wdata[15:0] == mso_pkg::HALT_TORQUE);
      mso_pkg::OFS_QS_REACT: wr_ok = qs_code_ok(par_wdata[15:0]);
      mso_pkg::OFS_DOUT: wr_ok = 1'b1;
      mso_pkg::OFS_QS_CURR: wr_ok = par_wdata[15:0] <= CURR_MAX;
      mso_pkg::OFS_HALT_CURR: wr_ok = par_wdata[15:0] <= CURR_MAX;
      default: wr_ok = 1'b0;
    endcase
  end

  // Parameter storage
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      qs_decel_q <= mso_pkg::RST_QS_DECEL;
      halt_react_q <= mso_pkg::RST_HALT_REACT;
      qs_react_q <= mso_pkg::RST_QS_REACT;
      dout_set_q <= mso_pkg::RST_DOUT;
      qs_curr_q <= CURR_RST;
      halt_curr_q <= CURR_RST;
    end else if (par_wr && wr_ok) begin
      case (par_addr)
        mso_pkg::OFS_QS_DECEL: qs_decel_q <= par_wdata;
        mso_pkg::OFS_HALT_REACT: halt_react_q <= par_wdata[15:0];
        mso_pkg::OFS_QS_REACT: qs_react_q <= par_wdata[15:0];
        mso_pkg::OFS_DOUT: dout_set_q <= (par_wdata[15:0] & free16) | (dout_set_q & ~free16);
        mso_pkg::OFS_QS_CURR: qs_curr_q <= par_wdata[15:0];
        mso_pkg::OFS_HALT_CURR: halt_curr_q <= par_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Read port and access answer, one cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      par_rdata_q <= '0;
      par_ack_q <= 1'b0;
      par_nak_q <= 1'b0;
    end else begin
      par_ack_q <= (par_wr && wr_ok) || (par_rd && !par_wr);
      par_nak_q <= par_wr && !wr_ok;
      if (par_rd && !par_wr) begin
        case (par_addr)
          mso_pkg::OFS_QS_DECEL: par_rdata_q <= qs_decel_q;
          mso_pkg::OFS_HALT_REACT: par_rdata_q <= {16'h0000, halt_react_q};
          mso_pkg::OFS_QS_REACT: par_rdata_q <= {16'h0000, qs_react_q};
          mso_pkg::OFS_DOUT: par_rdata_q <= {16'h0000, dout_set_q};
          mso_pkg::OFS_QS_CURR: par_rdata_q <= {16'h0000, qs_curr_q};
          mso_pkg::OFS_HALT_CURR: par_rdata_q <= {16'h0000, halt_curr_q};
          default: par_rdata_q <= '0;
        endcase
      end
    end
  end

  // Quick stop ramp in use is taken over only when a movement starts
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      qs_decel_act_q <= mso_pkg::RST_QS_DECEL;
    end else if (move_start) begin
      qs_decel_act_q <= qs_decel_q;
    end
  end

  // Stop sequencing; Quick Stop overrides Halt
  always_comb begin
    state_d = state_q;
    case (state_q)
      mso_pkg::MSO_RUN: begin
        if (halt_req) begin
          state_d = mso_pkg::MSO_HALT_BRAKE;
        end
      end
      mso_pkg::MSO_HALT_BRAKE: begin
        if (standstill) begin
          state_d = halt_req ? mso_pkg::MSO_HALT_HOLD : mso_pkg::MSO_RESUME;
        end
      end
      mso_pkg::MSO_HALT_HOLD: begin
        if (!halt_req) begin
          state_d = mso_pkg::MSO_RESUME;
        end
      end
      mso_pkg::MSO_RESUME: state_d = mso_pkg::MSO_RUN;
      mso_pkg::MSO_QS_BRAKE: begin
        if (standstill) begin
          state_d = qs_to_fault ? mso_pkg::MSO_FAULT : mso_pkg::MSO_QS_ACTIVE;
        end
      end
      mso_pkg::MSO_QS_ACTIVE: begin
        if (qstop_release) begin
          state_d = mso_pkg::MSO_RUN;
        end
      end
      mso_pkg::MSO_FAULT: begin
        if (fault_reset) begin
          state_d = mso_pkg::MSO_RUN;
        end
      end
      default: state_d = mso_pkg::MSO_RUN;
    endcase
    if (qs_req && state_q != mso_pkg::MSO_FAULT && state_q != mso_pkg::MSO_QS_ACTIVE) begin
      state_d = mso_pkg::MSO_QS_BRAKE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= mso_pkg::MSO_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Braking commands follow the state one cycle later
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      brake_active_q <= 1'b0;
      brake_torque_q <= 1'b0;
      brake_decel_q <= '0;
      brake_current_q <= '0;
      resume_q <= 1'b0;
      op_state_q <= mso_pkg::OPST_ENABLED;
    end else begin
      resume_q <= state_q == mso_pkg::MSO_RESUME;
      case (state_q)
        mso_pkg::MSO_HALT_BRAKE, mso_pkg::MSO_HALT_HOLD: begin
          brake_active_q <= 1'b1;
          brake_torque_q <= halt_tq;
          brake_decel_q <= profile_deceleration;
          brake_current_q <= halt_curr_q;
          op_state_q <= mso_pkg::OPST_ENABLED;
        end
        mso_pkg::MSO_QS_BRAKE, mso_pkg::MSO_QS_ACTIVE, mso_pkg::MSO_FAULT: begin
          brake_active_q <= 1'b1;
          brake_torque_q <= qs_tq;
          brake_decel_q <= qs_decel_act_q;
          brake_current_q <= qs_curr_q;
          op_state_q <= (state_q == mso_pkg::MSO_FAULT) ? mso_pkg::OPST_FAULT :
                        (state_q == mso_pkg::MSO_QS_ACTIVE) ? mso_pkg::OPST_QSTOP : mso_pkg::OPST_ENABLED;
        end
        default: begin
          brake_active_q <= 1'b0;
          brake_torque_q <= 1'b0;
          brake_decel_q <= '0;
          brake_current_q <= '0;
          op_state_q <= mso_pkg::OPST_ENABLED;
        end
      endcase
    end
  end

  mso_dout #(
    .N_OUT(N_OUT)
  ) u_dout (
    .mclk(mclk),
    .resetn(resetn),
    .set_bits(dout_set_q[N_OUT-1:0]),
    .free_use(out_free_use),
    .func_level(out_func_level),
    .dout_q(dout_q)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  halt_entry_a: assert property (state_q == mso_pkg::MSO_RUN && halt_req && !qs_req |=>
    state_q == mso_pkg::MSO_HALT_BRAKE ##1 brake_active_q)
    else $error("Halt did not start braking");

  halt_input_a: assert property (state_q == mso_pkg::MSO_RUN && !fb_halt && !halt_func_en && !qs_req |=>
    state_q == mso_pkg::MSO_RUN)
    else $error("Unassigned halt input acted");

  halt_brake_on_a: assert property (state_q == mso_pkg::MSO_HALT_BRAKE && !standstill && !qs_req |=>
    state_q == mso_pkg::MSO_HALT_BRAKE)
    else $error("Halt braking left before standstill");

  halt_resume_a: assert property (state_q == mso_pkg::MSO_HALT_BRAKE && standstill && !halt_req && !qs_req |=>
    state_q == mso_pkg::MSO_RESUME ##1 resume_q)
    else $error("No resume after withdrawn halt");

  halt_method_a: assert property (state_q == mso_pkg::MSO_HALT_BRAKE |=>
    brake_torque_q == ($past(halt_react_q) == mso_pkg::HALT_TORQUE || !$past(profile_mode)))
    else $error("Halt braking method wrong");

  mode_torque_a: assert property (brake_active_q && !$past(profile_mode) |-> brake_torque_q)
    else $error("Deceleration ramp used without velocity profile");

  halt_decel_a: assert property (state_q == mso_pkg::MSO_HALT_BRAKE |=>
    brake_decel_q == $past(profile_deceleration) && brake_current_q == $past(halt_curr_q))
    else $error("Halt ramp values wrong");

  qs_entry_a: assert property (qs_req && state_q != mso_pkg::MSO_FAULT && state_q != mso_pkg::MSO_QS_ACTIVE |=>
    state_q == mso_pkg::MSO_QS_BRAKE)
    else $error("Quick Stop not started");

  qs_final_a: assert property (state_q == mso_pkg::MSO_QS_BRAKE && standstill && !qs_req |=>
    state_q == ($past(qs_react_q[15]) ? mso_pkg::MSO_FAULT : mso_pkg::MSO_QS_ACTIVE) ##1
    op_state_q == ($past(qs_react_q[15], 2) ? mso_pkg::OPST_FAULT : mso_pkg::OPST_QSTOP))
    else $error("Quick Stop final state wrong");

  qs_range_a: assert property (qs_decel_q >= mso_pkg::QS_DECEL_MIN && qs_decel_q <= mso_pkg::QS_DECEL_MAX)
    else $error("Quick stop ramp out of range");

  qs_ramp_hold_a: assert property (!move_start |=> $stable(qs_decel_act_q))
    else $error("Quick stop ramp changed during movement");

  qs_values_a: assert property (state_q == mso_pkg::MSO_QS_BRAKE |=>
    brake_current_q == $past(qs_curr_q) && brake_decel_q == $past(qs_decel_act_q))
    else $error("Quick stop ramp values wrong");

endmodule
`default_nettype wire

// ==== logic/mso_pkg.sv ====
`default_nettype none
package mso_pkg;

  localparam int unsigned PAR_AW = 16;
  localparam int unsigned PAR_DW = 32;

  // Parameter offsets as seen from the fieldbus
  localparam logic [15:0] OFS_QS_DECEL = 16'h0624;
  localparam logic [15:0] OFS_HALT_REACT = 16'h062e;
  localparam logic [15:0] OFS_QS_REACT = 16'h0630;
  localparam logic [15:0] OFS_DOUT = 16'h0822;
  localparam logic [15:0] OFS_QS_CURR = 16'h110a;
  localparam logic [15:0] OFS_HALT_CURR = 16'h110c;

  // Values after reset
  localparam logic [31:0] RST_QS_DECEL = 32'h0000_1770;
  localparam logic [15:0] RST_HALT_REACT = 16'h0003;
  localparam logic [15:0] RST_QS_REACT = 16'h0007;
  localparam logic [15:0] RST_DOUT = 16'h0000;

  // Quick stop ramp limits in RPM/s
  localparam logic [31:0] QS_DECEL_MIN = 32'h0000_00c8;
  localparam logic [31:0] QS_DECEL_MAX = 32'h002d_c6c0;

  // Halt reaction codes
  localparam logic [15:0] HALT_DECEL = 16'h0001;
  localparam logic [15:0] HALT_TORQUE = 16'h0003;

  // Quick stop reaction codes (signed 16 bit)
  localparam logic [15:0] QSR_TQ_FAULT = 16'hfffe;
  localparam logic [15:0] QSR_DEC_FAULT = 16'hffff;
  localparam logic [15:0] QSR_DEC_STAY = 16'h0006;
  localparam logic [15:0] QSR_TQ_STAY = 16'h0007;

  // Operating state numbers shown on op_state_q
  localparam logic [3:0] OPST_ENABLED = 4'h6;
  localparam logic [3:0] OPST_QSTOP = 4'h7;
  localparam logic [3:0] OPST_FAULT = 4'h9;

  typedef enum logic [2:0] {
    MSO_RUN = 3'b000,
    MSO_HALT_BRAKE = 3'b001,
    MSO_HALT_HOLD = 3'b011,
    MSO_RESUME = 3'b010,
    MSO_QS_BRAKE = 3'b110,
    MSO_QS_ACTIVE = 3'b111,
    MSO_FAULT = 3'b101
  } mso_state_e;

endpackage
`default_nettype wire

// ==== logic/mso_dout.sv ====
`timescale 1ns/1ns
`default_nettype none
module mso_dout #(
  parameter int unsigned N_OUT = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [N_OUT-1:0] set_bits,
  input wire logic [N_OUT-1:0] free_use,
  input wire logic [N_OUT-1:0] func_level,
  output logic [N_OUT-1:0] dout_q
);

  if (N_OUT < 1 || N_OUT > 16) begin : g_nout_chk
    $error("mso_dout: N_OUT must be 1 to 16");
  end

  // Bit i of the set value drives output i only when it is free for use
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dout_q <= '0;
    end else begin
      dout_q <= (set_bits & free_use) | (func_level & ~free_use);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  dout_func_keep_a: assert property (##1 ((dout_q ^ $past(func_level)) & ~$past(free_use)) == '0)
    else $error("Output not free for use was driven by the set value");

  dout_bit_map_a: assert property (##1 ((dout_q ^ $past(set_bits)) & $past(free_use)) == '0)
    else $error("Free output does not follow its set bit");

endmodule
`default_nettype wire

// ==== verif/mso_fb_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module mso_fb_master (
  input wire logic mclk,
  input wire logic [31:0] par_rdata_q,
  input wire logic par_ack_q,
  input wire logic par_nak_q,
  output logic par_wr,
  output logic par_rd,
  output logic [15:0] par_addr,
  output logic [31:0] par_wdata
);
  initial begin
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_addr = 16'h0000;
    par_wdata = 32'h0000_0000;
  end
  // One-edge strobe, then a bounded wait for the registered answer
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic ack, output logic nak);
    int n;
    @(negedge mclk);
    par_wr = wr;
    par_rd = !wr;
    par_addr = a;
    par_wdata = d;
    @(negedge mclk);
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_addr = ~a;
    par_wdata = ~d;
    for (n = 0; n < 3 && par_ack_q !== 1'b1 && par_nak_q !== 1'b1; n++) begin
      @(negedge mclk);
    end
    r = par_rdata_q;
    ack = par_ack_q;
    nak = par_nak_q;
  endtask
endmodule
`default_nettype wire

// ==== verif/mso_stop_ctrl_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module mso_stop_ctrl_tb_top;
  logic mclk, resetn, halt_in, halt_func_en, fb_halt, fb_qstop, err_class1, err_class2;
  logic qstop_release, fault_reset, profile_mode, standstill, move_start;
  logic [31:0] profile_deceleration;
  logic [15:0] out_free_use, out_func_level;
  logic par_wr, par_rd, par_ack_q, par_nak_q, brake_active_q, brake_torque_q, resume_q;
  logic [15:0] par_addr, brake_current_q, dout_q;
  logic [31:0] par_wdata, par_rdata_q, brake_decel_q;
  logic [3:0] op_state_q;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  mso_stop_ctrl dut_u (.mclk, .resetn, .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata_q,
    .par_ack_q, .par_nak_q, .halt_in, .halt_func_en, .fb_halt, .fb_qstop, .err_class1, .err_class2,
    .qstop_release, .fault_reset, .profile_mode, .standstill, .move_start, .profile_deceleration,
    .brake_active_q, .brake_torque_q, .brake_decel_q, .brake_current_q, .resume_q, .op_state_q,
    .out_free_use, .out_func_level, .dout_q);
  mso_fb_master fbm_u (.mclk, .par_rdata_q, .par_ack_q, .par_nak_q, .par_wr, .par_rd, .par_addr,
    .par_wdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report;
    end
  end
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic bad);
    logic [31:0] r;
    logic ak, nk;
    fbm_u.access(1'b1, a, d, r, ak, nk);
    `CHK("write answer", {!bad, bad}, {ak, nk})
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic ak, nk;
    fbm_u.access(1'b0, a, 32'h0, r, ak, nk);
    `CHK("read data", {1'b1, e}, {ak, r})
  endtask
  task automatic t_reset;
    `CHK("op state", 4'h6, op_state_q)
    rd(mso_pkg::OFS_QS_DECEL, 32'h0000_1770);
    rd(mso_pkg::OFS_HALT_REACT, 32'h0000_0003);
    rd(mso_pkg::OFS_QS_REACT, 32'h0000_0007);
    rd(mso_pkg::OFS_DOUT, 32'h0000_0000);
    rd(mso_pkg::OFS_HALT_CURR, 32'h0000_01f4);
    rd(mso_pkg::OFS_QS_CURR, 32'h0000_01f4);
    rd(16'h0002, 32'h0000_0000);
  endtask
  task automatic t_limits;
    wr(mso_pkg::OFS_QS_DECEL, 32'h0000_00c7, 1'b1);
    wr(mso_pkg::OFS_QS_DECEL, 32'h0000_00c8, 1'b0);
    wr(mso_pkg::OFS_QS_DECEL, 32'h002d_c6c1, 1'b1);
    wr(mso_pkg::OFS_QS_DECEL, 32'h002d_c6c0, 1'b0);
    rd(mso_pkg::OFS_QS_DECEL, 32'h002d_c6c0);
    wr(mso_pkg::OFS_QS_DECEL, 32'h0000_1770, 1'b0);
    wr(mso_pkg::OFS_HALT_REACT, 32'h0000_0002, 1'b1);
    wr(mso_pkg::OFS_QS_REACT, 32'h0000_fffd, 1'b1);
    wr(mso_pkg::OFS_QS_REACT, 32'h0000_0005, 1'b1);
    wr(mso_pkg::OFS_QS_CURR, 32'h0000_03e9, 1'b1);
    wr(mso_pkg::OFS_QS_CURR, 32'h0000_03e8, 1'b0);
    rd(mso_pkg::OFS_QS_CURR, 32'h0000_03e8);
    wr(16'h0002, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_halt;
    int n;
    halt_in = 1'b1;
    cyc(4);
    `CHK("unassigned input", 1'b0, brake_active_q)
    halt_func_en = 1'b1;
    cyc(3);
    `CHK("halt torque", 2'b11, {brake_active_q, brake_torque_q})
    `CHK("halt current", 16'h01f4, brake_current_q)
    wr(mso_pkg::OFS_HALT_CURR, 32'h0000_0100, 1'b0);
    cyc(2);
    `CHK("current at once", 16'h0100, brake_current_q)
    halt_in = 1'b0;
    cyc(4);
    `CHK("brake to rest", 2'b10, {brake_active_q, resume_q})
    standstill = 1'b1;
    for (n = 0; n < 8 && resume_q !== 1'b1; n++) cyc(1);
    `CHK("resume", 1'b1, resume_q)
    cyc(2);
    `CHK("running", 5'h06, {brake_active_q, op_state_q})
    standstill = 1'b0;
    halt_func_en = 1'b0;
  endtask
  task automatic t_halt_decel;
    wr(mso_pkg::OFS_HALT_REACT, 32'h0000_0001, 1'b0);
    profile_deceleration = 32'h0000_0bb8;
    fb_halt = 1'b1;
    cyc(3);
    `CHK("halt ramp", 2'b10, {brake_active_q, brake_torque_q})
    `CHK("profile decel", 32'h0000_0bb8, brake_decel_q)
    profile_mode = 1'b0;
    cyc(3);
    `CHK("no profile", 1'b1, brake_torque_q)
    profile_mode = 1'b1;
    wr(mso_pkg::OFS_HALT_REACT, 32'h0000_0003, 1'b0);
    cyc(2);
    `CHK("react at once", 1'b1, brake_torque_q)
    fb_halt = 1'b0;
    standstill = 1'b1;
    cyc(6);
    standstill = 1'b0;
  endtask
  task automatic t_qstop;
    logic [15:0] codes [4] = '{16'hfffe, 16'hffff, 16'h0006, 16'h0007};
    logic tq;
    for (int i = 0; i < 4; i++) begin
      wr(mso_pkg::OFS_QS_REACT, {16'h0, codes[i]}, 1'b0);
      profile_mode = (i != 1);
      tq = codes[i] == 16'hfffe || codes[i] == 16'h0007 || i == 1;
      if (i == 0) fb_qstop = 1'b1;
      else if (i == 1) err_class1 = 1'b1;
      else err_class2 = 1'b1;
      cyc(1);
      {fb_qstop, err_class1, err_class2} = 3'b000;
      cyc(2);
      `CHK("qs brake", {1'b1, tq}, {brake_active_q, brake_torque_q})
      `CHK("qs current", 16'h03e8, brake_current_q)
      standstill = 1'b1;
      cyc(4);
      fb_qstop = 1'b1;
      cyc(1);
      fb_qstop = 1'b0;
      cyc(2);
      `CHK("qs end state", codes[i][15] ? 4'h9 : 4'h7, op_state_q)
      if (codes[i][15]) fault_reset = 1'b1;
      else qstop_release = 1'b1;
      cyc(1);
      {fault_reset, qstop_release, standstill} = 3'b000;
      cyc(3);
      `CHK("back to run", 4'h6, op_state_q)
    end
    profile_mode = 1'b1;
  endtask
  task automatic t_qs_ramp;
    wr(mso_pkg::OFS_QS_REACT, 32'h0000_0006, 1'b0);
    for (int k = 0; k < 2; k++) begin
      move_start = 1'b1;
      cyc(1);
      move_start = 1'b0;
      if (k == 0) wr(mso_pkg::OFS_QS_DECEL, 32'h0000_03e8, 1'b0);
      fb_qstop = 1'b1;
      cyc(1);
      fb_qstop = 1'b0;
      cyc(3);
      `CHK("qs ramp", k ? 32'h0000_03e8 : 32'h0000_1770, brake_decel_q)
      standstill = 1'b1;
      cyc(4);
      qstop_release = 1'b1;
      cyc(1);
      {qstop_release, standstill} = 2'b00;
      cyc(3);
    end
  endtask
  task automatic t_dout;
    out_free_use = 16'h00ff;
    out_func_level = 16'ha500;
    wr(mso_pkg::OFS_DOUT, 32'h0000_5a5a, 1'b0);
    cyc(2);
    `CHK("outputs", 16'ha55a, dout_q)
    out_free_use = 16'hff00;
    out_func_level = 16'h0000;
    cyc(2);
    `CHK("ignored bits", 16'h0000, dout_q)
    wr(mso_pkg::OFS_DOUT, 32'h0000_8001, 1'b0);
    cyc(2);
    `CHK("upper bit", 16'h8000, dout_q)
  endtask
  initial begin
    resetn = 1'b0;
    {halt_in, halt_func_en, fb_halt, fb_qstop, err_class1, err_class2} = 6'h00;
    {qstop_release, fault_reset, standstill, move_start} = 4'h0;
    profile_mode = 1'b1;
    profile_deceleration = 32'h0000_02ee;
    out_free_use = 16'h0000;
    out_func_level = 16'h0000;
    cyc(6);
    resetn = 1'b1;
    cyc(1);
    t_reset;
    t_limits;
    t_halt;
    t_halt_decel;
    t_qstop;
    t_qs_ramp;
    t_dout;
    final_report;
  end
endmodule
`default_nettype wire
